// [hw/aor_resolver.sv]
// Purpose: resolve operand addresses of an ALU clause and keep per-clause state
// Assumes: clause sequencer on the same clock; Wishbone master on the same clock
// Notes:   one operand in flight; result two cycles after acceptance at best
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module aor_resolver
    import aor_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        clause_start_i,
    input  wire aor_cfw_s    clause_control_word_i,
    input  wire logic        clause_end_i,
    input  wire logic        load_index_op_i,
    input  wire aor_lanes_t  load_index_val_i,
    input  wire logic [8:0]  loop_index_i,
    input  wire logic        group_done_i,
    input  wire logic        nop_group_i,
    input  wire aor_vec_t    group_result_i,
    input  wire logic [2:0]  group_slots_i,
    input  wire logic        req_valid_i,
    input  wire aor_req_s    req_i,
    output logic             req_ready_o,
    output aor_res_s         res_o,
    output logic [31:0]      res_data_o,
    output aor_vec_t         previous_result_vector_o,
    output logic             stall_o
);
    logic [6:0]      clause_temp_count_r;
    logic [7:0]      declared_r;
    aor_cfw_s        cfw_r;
    aor_lanes_t      index_register_r;
    logic            index_valid_r;
    logic [1:0]      gap_r;
    logic [6:0]      wf_cnt_r;
    logic [15:0]     slot_cnt_r;
    logic            pv_valid_r;
    aor_req_s        req_q;
    aor_st_e         state_r;
    aor_st_e         state_nxt;
    aor_res_s        res_r;
    aor_res_s        res_nxt;
    logic [31:0]     res_data_r;
    logic            ready_r;
    logic            stall_r;
    logic [31:0]     wb_dat_r;
    logic            wb_ack_r;
    aor_vec_t        pv_r;

    logic            is_gpr;
    logic            is_kc0;
    logic            is_kc1;
    logic            is_creg;
    logic            ar_use;
    logic            kc_bad;
    logic            in_decl;
    logic            finish;
    logic [8:0]      base;
    logic [8:0]      index_sel;
    logic signed [9:0] hi_bound;
    logic signed [9:0] final_addr;
    logic            oob;
    logic [8:0]      temp_base;
    logic            wb_req;

    function automatic logic [7:0] line_of(input aor_bank_s b, input logic [8:0] a,
                                           input logic [8:0] loop_v);
        logic [7:0] off;
        off = b.loop_rel ? loop_v[7:0] : 8'h00;
        return b.line + {7'h00, a[4]} + off;
    endfunction : line_of

    // operand decode
    always_comb begin
        is_gpr  = (req_q.kind == KIND_SEL) && (req_q.sel < SEL_KC0_BASE);
        is_kc0  = (req_q.kind == KIND_SEL) && (req_q.sel >= SEL_KC0_BASE)
                  && (req_q.sel < SEL_KC1_BASE);
        is_kc1  = (req_q.kind == KIND_SEL) && (req_q.sel >= SEL_KC1_BASE)
                  && (req_q.sel < SEL_KC_END);
        is_creg = (req_q.kind == KIND_CREG);
        base    = req_q.sel;
        if (is_kc0) begin
            base = req_q.sel - SEL_KC0_BASE;
        end else if (is_kc1) begin
            base = req_q.sel - SEL_KC1_BASE;
        end
        // loop option for every type; lane X for registers, named lane for constants
        if (req_q.mode == IDX_LOOP) begin
            index_sel = loop_index_i;
        end else if (is_creg) begin
            index_sel = index_register_r[req_q.mode[1:0]];
        end else begin
            index_sel = index_register_r[0];
        end
        ar_use  = req_q.rel && (req_q.mode != IDX_LOOP) && (is_gpr || is_creg);
        kc_bad  = (is_kc0 || is_kc1) && req_q.rel && (req_q.mode != IDX_LOOP);
        in_decl = {1'b0, base[7:0]} < {1'b0, declared_r} && !base[8];
        if (is_gpr) begin
            hi_bound = $signed({2'b00, declared_r}) - 10'sd1;
        end else if (is_creg) begin
            hi_bound = $signed(CREG_MAX);
        end else if (cfw_r.lock == TWO_LINES) begin
            hi_bound = $signed(KC_TWO_MAX);
        end else begin
            hi_bound = $signed(KC_ONE_MAX);
        end
        temp_base = {1'b0, GPR_COUNT} - {2'b00, clause_temp_count_r};
    end

    aor_index_add #(
        .W       (ADDR_W)
    ) u_add (
        .base_i  (base),
        .rel_i   (req_q.rel),
        .index_i ($signed(index_sel)),
        .hi_i    (hi_bound),
        .final_o (final_addr),
        .oob_o   (oob)
    );

    // result assembly
    always_comb begin
        res_nxt          = '0;
        res_nxt.valid    = 1'b1;
        res_nxt.addr     = final_addr[8:0];
        res_nxt.alt      = cfw_r.alt;
        res_nxt.target   = TGT_PV;
        if (is_gpr) begin
            res_nxt.target = TGT_GPR;
            res_nxt.temp   = (clause_temp_count_r != 7'h00)
                             && (final_addr >= $signed({1'b0, temp_base}));
            if (req_q.rel && in_decl && oob) begin
                if (!req_q.write || req_q.mem_read) begin
                    res_nxt.addr = 9'h000;
                end else begin
                    res_nxt.suppress = 1'b1;
                end
            end
        end else if (is_creg) begin
            res_nxt.target = TGT_CREG;
            res_nxt.nan    = req_q.rel && oob;
        end else if (is_kc0 || is_kc1) begin
            res_nxt.target = is_kc0 ? TGT_KC0 : TGT_KC1;
            res_nxt.nan    = req_q.rel && (oob || kc_bad);
            res_nxt.buf_id = is_kc0 ? cfw_r.bank0.buf_id : cfw_r.bank1.buf_id;
            res_nxt.line   = line_of(is_kc0 ? cfw_r.bank0 : cfw_r.bank1,
                                     final_addr[8:0], loop_index_i);
        end
    end

    // sequencing: load gap and per-pixel serialisation
    always_comb begin
        state_nxt = state_r;
        finish    = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (req_valid_i && ready_r) begin
                    state_nxt = ST_EVAL;
                end
            end
            ST_EVAL: begin
                if (ar_use && (gap_r != 2'h0)) begin
                    state_nxt = ST_GAP;
                end else if (ar_use && is_creg && (req_q.pix_reads > 7'h01)) begin
                    state_nxt = ST_WFALL;
                end else begin
                    state_nxt = ST_IDLE;
                    finish    = 1'b1;
                end
            end
            ST_GAP: begin
                if (gap_r <= 2'h1) begin
                    state_nxt = ST_EVAL;
                end
            end
            ST_WFALL: begin
                if (wf_cnt_r <= 7'h01) begin
                    state_nxt = ST_IDLE;
                    finish    = 1'b1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            ready_r <= 1'b0;
            stall_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ready_r <= (state_nxt == ST_IDLE) && !(req_valid_i && ready_r);
            stall_r <= (state_nxt == ST_GAP) || (state_nxt == ST_WFALL);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_q <= '0;
        end else if (req_valid_i && ready_r && (state_r == ST_IDLE)) begin
            req_q <= req_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wf_cnt_r <= 7'h00;
        end else if (state_r == ST_EVAL) begin
            wf_cnt_r <= (req_q.pix_reads > WFALL_MAX) ? WFALL_MAX : req_q.pix_reads;
        end else if (state_r == ST_WFALL) begin
            wf_cnt_r <= wf_cnt_r - 7'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_r      <= '0;
            res_data_r <= 32'h0000_0000;
        end else if (finish) begin
            res_r      <= res_nxt;
            res_data_r <= res_nxt.nan ? NAN_VALUE : 32'h0000_0000;
        end else begin
            res_r.valid <= 1'b0;
        end
    end

    // index register and load gap
    always_ff @(posedge clk_i) begin
        if (rst_i || clause_end_i || clause_start_i) begin
            index_register_r <= '0;
            index_valid_r    <= 1'b0;
            gap_r            <= 2'h0;
        end else if (load_index_op_i) begin
            index_register_r <= load_index_val_i;
            index_valid_r    <= 1'b1;
            gap_r            <= LOAD_GAP;
        end else if ((gap_r != 2'h0) && (group_done_i || (state_r == ST_GAP))) begin
            gap_r <= gap_r - 2'h1;
        end
    end

    // previous-result vector
    always_ff @(posedge clk_i) begin
        if (rst_i || clause_end_i || clause_start_i) begin
            pv_r       <= '0;
            pv_valid_r <= 1'b0;
        end else if (group_done_i) begin
            pv_r       <= nop_group_i ? '0 : group_result_i;
            pv_valid_r <= !nop_group_i;
        end
    end

    // clause control word and slot accounting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfw_r      <= '0;
            slot_cnt_r <= 16'h0000;
        end else if (clause_start_i) begin
            cfw_r      <= clause_control_word_i;
            slot_cnt_r <= 16'h0000;
        end else if (group_done_i) begin
            slot_cnt_r <= slot_cnt_r + {13'h0000, group_slots_i};
        end
    end

    // wishbone slave
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clause_temp_count_r <= RST_TEMPS;
            declared_r          <= RST_DECLARED;
        end else if (wb_req && wb_we_i && (wb_adr_i == REG_CONFIG)) begin
            if (wb_sel_i[0]) begin
                clause_temp_count_r <= wb_dat_i[CFG_TEMP_LSB +: 7];
            end
            if (wb_sel_i[1]) begin
                declared_r <= wb_dat_i[CFG_DECL_LSB +: 8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_r <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else begin
            wb_ack_r <= wb_req;
            wb_dat_r <= 32'h0000_0000;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    REG_CONFIG: wb_dat_r <= {16'h0000, declared_r, 1'b0, clause_temp_count_r};
                    REG_STATUS: wb_dat_r <= {22'h00_0000, state_r, cfw_r.lock, cfw_r.alt,
                                             pv_valid_r, gap_r == 2'h0, index_valid_r};
                    REG_SLOTS:  wb_dat_r <= {16'h0000, slot_cnt_r};
                    default:    wb_dat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_dat_o                 = wb_dat_r;
    assign wb_ack_o                 = wb_ack_r;
    assign req_ready_o              = ready_r;
    assign res_o                    = res_r;
    assign res_data_o               = res_data_r;
    assign previous_result_vector_o = pv_r;
    assign stall_o                  = stall_r;

    chk_gpr_read_zero : assert property (@(posedge clk_i) disable iff (rst_i)
        finish && is_gpr && req_q.rel && in_decl && oob && !req_q.write
        |=> res_o.valid && res_o.addr == 9'h000 && !res_o.suppress)
        else $error("indexed register read out of range not sent to zero");
    chk_gpr_write_drop : assert property (@(posedge clk_i) disable iff (rst_i)
        finish && is_gpr && req_q.rel && in_decl && oob && req_q.write && !req_q.mem_read
        |=> res_o.suppress)
        else $error("out of range indexed write not suppressed");
    chk_creg_nan_value : assert property (@(posedge clk_i) disable iff (rst_i)
        finish && is_creg && req_q.rel && oob |=> res_o.nan && res_data_o == NAN_VALUE)
        else $error("constant read out of range did not give nan");
    chk_kc_nan_value : assert property (@(posedge clk_i) disable iff (rst_i)
        finish && (is_kc0 || is_kc1) && req_q.rel && (final_addr > 10'sd31)
        |=> res_o.nan)
        else $error("cached constant out of range did not give nan");
    chk_gap_stall : assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == ST_EVAL && ar_use && gap_r == LOAD_GAP && !group_done_i
        && !clause_end_i && !clause_start_i
        |=> stall_o [*2])
        else $error("index use right after load did not stall two cycles");
    chk_pv_nop_clear : assert property (@(posedge clk_i) disable iff (rst_i)
        group_done_i && nop_group_i |=> previous_result_vector_o == '0)
        else $error("nop group left previous results in place");
    chk_index_end : assert property (@(posedge clk_i) disable iff (rst_i)
        clause_end_i |=> !index_valid_r && gap_r == 2'h0)
        else $error("index register survived clause end");
    chk_temp_mark : assert property (@(posedge clk_i) disable iff (rst_i)
        finish && is_gpr && !req_q.rel && clause_temp_count_r != 7'h00
        && base >= temp_base |=> res_o.temp)
        else $error("clause temporary not marked");
    chk_alt_pass : assert property (@(posedge clk_i) disable iff (rst_i)
        finish |=> res_o.alt == $past(cfw_r.alt))
        else $error("alternate constants bit not carried");
endmodule : aor_resolver

// [hw/aor_pkg.sv]
// Purpose: shared constants, types and carriers of the operand address resolver
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes:   config, status and slot-count registers sit on a classic Wishbone slave
// Overview of operation
// - top K general registers are clause temporaries
// - constants index any lane, registers lane X
// - index select picks lane X, lane, or loop
// - one shared index, per-operand relative flags
// - previous results readable; nop groups, clause end clear
// - out-of-range indexed register read returns register zero
// - out-of-range indexed write dropped; memory read hits zero
// - constant read beyond 0..255 returns NaN
// - cached constant beyond locked lines returns NaN
// - constants are 32 bits wide
// - 16 buffers, 4096 entries, two 32-entry windows
// - two locked line pairs, optionally loop-offset
// - literal slots count toward clause size
// - per-pixel constant index serialises up to 64 reads
// - two-group load gap stalls; clause end invalidates
// - alternate-constants bit picks paired stage buffers
// - relative flag adds chosen index to address
// - select 0-127 register, 128-159 bank0, 160-191 bank1
package aor_pkg;

    localparam int unsigned ADDR_W       = 9;
    localparam int unsigned DATA_W       = 32;
    localparam logic [8:0]  SEL_KC0_BASE = 9'h080;
    localparam logic [8:0]  SEL_KC1_BASE = 9'h0A0;
    localparam logic [8:0]  SEL_KC_END   = 9'h0C0;
    localparam logic [7:0]  GPR_COUNT    = 8'h80;
    localparam logic [9:0]  CREG_MAX     = 10'h0FF;
    localparam logic [9:0]  KC_ONE_MAX   = 10'h00F;
    localparam logic [9:0]  KC_TWO_MAX   = 10'h01F;
    localparam logic [31:0] NAN_VALUE    = 32'h07FF_FFFF;
    localparam logic [1:0]  LOAD_GAP     = 2'h2;
    localparam logic [6:0]  WFALL_MAX    = 7'h40;
    localparam int unsigned NUM_BUFFERS  = 16;
    localparam int unsigned BUF_ENTRIES  = 4096;
    localparam int unsigned LINE_ENTRIES = 16;

    localparam logic [3:0]  REG_CONFIG   = 4'h0;
    localparam logic [3:0]  REG_STATUS   = 4'h4;
    localparam logic [3:0]  REG_SLOTS    = 4'h8;
    localparam logic [6:0]  RST_TEMPS    = 7'h00;
    localparam logic [7:0]  RST_DECLARED = 8'h80;
    localparam int unsigned CFG_TEMP_LSB = 0;
    localparam int unsigned CFG_DECL_LSB = 8;

    typedef enum logic [2:0] {
        IDX_X = 3'h0, IDX_Y = 3'h1, IDX_Z = 3'h2, IDX_W = 3'h3, IDX_LOOP = 3'h4
    } aor_idx_e;

    typedef enum logic [1:0] {KIND_SEL = 2'h0, KIND_CREG = 2'h1, KIND_PV = 2'h2} aor_kind_e;
    typedef enum logic [2:0] {
        TGT_GPR = 3'h0, TGT_CREG = 3'h1, TGT_KC0 = 3'h2, TGT_KC1 = 3'h3, TGT_PV = 3'h4
    } aor_tgt_e;
    typedef enum logic [1:0] {NO_LINES = 2'h0, ONE_LINE = 2'h1, TWO_LINES = 2'h2} aor_lock_e;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001, ST_EVAL = 4'b0010, ST_GAP = 4'b0100, ST_WFALL = 4'b1000
    } aor_st_e;

    typedef logic [3:0][8:0]  aor_lanes_t;
    typedef logic [3:0][31:0] aor_vec_t;

    typedef struct packed {
        aor_kind_e   kind;
        logic [8:0]  sel;
        logic        rel;
        aor_idx_e    mode;
        logic        write;
        logic        mem_read;
        logic [6:0]  pix_reads;
    } aor_req_s;

    typedef struct packed {
        logic [3:0]  buf_id;
        logic [7:0]  line;
        logic        loop_rel;
    } aor_bank_s;

    typedef struct packed {
        aor_lock_e   lock;
        logic        alt;
        aor_bank_s   bank0;
        aor_bank_s   bank1;
    } aor_cfw_s;

    typedef struct packed {
        logic        valid;
        aor_tgt_e    target;
        logic [8:0]  addr;
        logic        temp;
        logic        nan;
        logic        suppress;
        logic        alt;
        logic [3:0]  buf_id;
        logic [7:0]  line;
    } aor_res_s;

endpackage : aor_pkg

// [hw/aor_index_add.sv]
// Purpose: signed base-plus-index with range check
// Assumes: combinational, bounds given signed one bit wider than base
// Notes:   an absolute operand passes its base unchanged
`timescale 1ns/1ps
module aor_index_add
    import aor_pkg::*;
#(
    parameter int unsigned W = ADDR_W
) (
    input  wire logic [W-1:0]        base_i,
    input  wire logic                rel_i,
    input  wire logic signed [W-1:0] index_i,
    input  wire logic signed [W:0]   hi_i,
    output logic signed [W:0]        final_o,
    output logic                     oob_o
);
    always_comb begin
        final_o = $signed({1'b0, base_i});
        if (rel_i) begin
            final_o = $signed({1'b0, base_i}) + $signed({index_i[W-1], index_i});
        end
        oob_o = (final_o < 0) || (final_o > hi_i);
    end
endmodule : aor_index_add

// [verification/aor_seq_model.sv]
// Purpose: clause sequencer model that drives clause strobes and groups
// Assumes: shares clk_i with the resolver; strobes are one cycle wide
// Notes:   released data lines show the inverse of their last value
`timescale 1ns/1ps
module aor_seq_model
    import aor_pkg::*;
(
    input  wire logic  clk_i,
    output aor_cfw_s   cfw_o,
    output logic       start_o,
    output logic       end_o,
    output logic       load_o,
    output aor_lanes_t lanes_o,
    output logic [8:0] loop_o,
    output logic       done_o,
    output logic       nop_o,
    output aor_vec_t   vec_o,
    output logic [2:0] slots_o
);
    initial begin
        cfw_o = '0;
        {start_o, end_o, load_o, done_o, nop_o} = '0;
        lanes_o = '0;
        loop_o = '0;
        vec_o = '0;
        slots_o = '0;
    end
    task automatic clause(input aor_cfw_s w);
        @(posedge clk_i);
        cfw_o <= w;
        start_o <= 1'h1;
        @(posedge clk_i);
        cfw_o <= ~w;
        start_o <= 1'h0;
    endtask : clause
    task automatic end_clause();
        @(posedge clk_i);
        end_o <= 1'h1;
        @(posedge clk_i);
        end_o <= 1'h0;
    endtask : end_clause
    // index load in a group of its own, ahead of any indexed use
    task automatic load(input aor_lanes_t v);
        @(posedge clk_i);
        lanes_o <= v;
        load_o <= 1'h1;
        @(posedge clk_i);
        lanes_o <= ~v;
        load_o <= 1'h0;
    endtask : load
    // loop index held as a level
    task automatic set_loop(input logic [8:0] v);
        @(posedge clk_i);
        loop_o <= v;
    endtask : set_loop
    // finished group with results and slot count
    task automatic group(input logic n, input aor_vec_t v, input logic [2:0] s);
        @(posedge clk_i);
        {done_o, nop_o, vec_o, slots_o} <= {1'h1, n, v, s};
        @(posedge clk_i);
        {done_o, nop_o, vec_o, slots_o} <= {1'h0, ~n, ~v, ~s};
    endtask : group
endmodule : aor_seq_model

// [verification/alu_operand_address_resolver_tb_top.sv]
// Purpose: self-checking bench of the operand address resolver
// Assumes: 100 MHz clock, synchronous reset held ten cycles
// Notes:   sixteen declared registers and four clause temporaries
`timescale 1ns/1ps
module alu_operand_address_resolver_tb_top
    import aor_pkg::*;
;
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic [3:0]  wb_adr_i = '0;
    logic [3:0]  wb_sel_i = '0;
    logic [31:0] wb_dat_i = '0;
    logic        wb_we_i = 1'h0;
    logic        wb_cyc_i = 1'h0;
    logic        wb_stb_i = 1'h0;
    logic        req_valid_i = 1'h0;
    aor_req_s    req_i = '0;
    logic [31:0] wb_dat_o, res_data_o, q;
    logic        wb_ack_o, req_ready_o, stall_o, cs, ce, li, gd, ng, stall_seen;
    aor_res_s    res_o;
    aor_vec_t    pv, gr;
    aor_cfw_s    cw;
    aor_lanes_t  lv;
    logic [8:0]  lp;
    logic [2:0]  gs;
    int          error_cnt = 0;
    int          checks = 0;
    always #5 clk_i = ~clk_i;
    aor_seq_model u_seq (
        .clk_i, .cfw_o(cw), .start_o(cs), .end_o(ce), .load_o(li), .lanes_o(lv),
        .loop_o(lp), .done_o(gd), .nop_o(ng), .vec_o(gr), .slots_o(gs)
    );
    aor_resolver DUT (
        .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
        .wb_dat_o, .wb_ack_o, .clause_start_i(cs), .clause_control_word_i(cw),
        .clause_end_i(ce), .load_index_op_i(li), .load_index_val_i(lv), .loop_index_i(lp),
        .group_done_i(gd), .nop_group_i(ng), .group_result_i(gr), .group_slots_i(gs),
        .req_valid_i, .req_i, .req_ready_o, .res_o, .res_data_o,
        .previous_result_vector_o(pv), .stall_o
    );
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic tmo();
        error_cnt++;
        report_and_stop();
    endtask : tmo
    task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_adr_i, wb_we_i, wb_dat_i, wb_sel_i} <= {2'h3, a, w, d, s};
        do begin
            @(posedge clk_i);
            n++;
            if (n > 50) tmo();
        end while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        wb(a, 1'h0, 32'h0000_0000, 4'hF);
        chk("register read", q, e);
    endtask : rd
    task automatic op(input aor_kind_e k, input logic [8:0] s, input logic r,
                      input aor_idx_e m, input logic [1:0] wm, input logic [6:0] px,
                      input aor_tgt_e t, input logic [8:0] a, input logic [2:0] f,
                      input int lat);
        int n;
        n = 0;
        stall_seen = 1'h0;
        @(posedge clk_i);
        req_valid_i <= 1'h1;
        req_i <= '{k, s, r, m, wm[1], wm[0], px}; // one index lane per group
        do begin
            @(posedge clk_i);
            n++;
            if (n > 200) tmo();
        end while (req_ready_o !== 1'h1);
        req_valid_i <= 1'h0;
        req_i <= ~req_i;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (stall_o === 1'h1) stall_seen = 1'h1;
            if (n > 200) tmo();
        end while (res_o.valid !== 1'h1);
        if (lat >= 0) chk("latency", n, lat);
        chk("target", res_o.target, t);
        if (!f[1]) chk("address", res_o.addr, a);
        chk("temp nan suppress", {res_o.temp, res_o.nan, res_o.suppress}, f);
        chk("data", res_data_o, f[1] ? NAN_VALUE : 32'h0000_0000);
    endtask : op
    // bases stay in range, temporaries absolute, cached constants also read past locked lines
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(REG_CONFIG, 32'h0000_8000);
        rd(4'hC, 32'h0000_0000);
        wb(REG_CONFIG, 1'h1, 32'h0000_1004, 4'hF);
        wb(REG_CONFIG, 1'h1, 32'h0000_3304, 4'h1);
        rd(REG_CONFIG, 32'h0000_1004);
        u_seq.clause('{ONE_LINE, 1'h0, '{4'h3, 8'h08, 1'h0}, '0});
        u_seq.set_loop(9'h003);
        op(KIND_SEL, 9'h005, 1'h1, IDX_LOOP, 2'h0, 7'h00, TGT_GPR, 9'h008, 3'h0, 2);
        op(KIND_SEL, 9'h07C, 1'h0, IDX_LOOP, 2'h0, 7'h00, TGT_GPR, 9'h07C, 3'h4, 2);
        op(KIND_SEL, 9'h07B, 1'h0, IDX_LOOP, 2'h0, 7'h00, TGT_GPR, 9'h07B, 3'h0, 2);
        op(KIND_SEL, 9'h08A, 1'h1, IDX_LOOP, 2'h0, 7'h00, TGT_KC0, 9'h00D, 3'h0, 2);
        op(KIND_CREG, 9'h0FC, 1'h1, IDX_LOOP, 2'h0, 7'h00, TGT_CREG, 9'h0FF, 3'h0, 2);
        u_seq.set_loop(9'h008);
        op(KIND_SEL, 9'h08A, 1'h1, IDX_LOOP, 2'h0, 7'h00, TGT_KC0, 9'h000, 3'h2, 2);
        op(KIND_SEL, 9'h00A, 1'h1, IDX_LOOP, 2'h2, 7'h00, TGT_GPR, 9'h012, 3'h1, 2);
        op(KIND_SEL, 9'h00A, 1'h1, IDX_LOOP, 2'h3, 7'h00, TGT_GPR, 9'h000, 3'h0, 2);
        op(KIND_CREG, 9'h0F8, 1'h1, IDX_LOOP, 2'h0, 7'h00, TGT_CREG, 9'h000, 3'h2, 2);
        u_seq.set_loop(9'h1F9);
        op(KIND_SEL, 9'h005, 1'h1, IDX_LOOP, 2'h0, 7'h00, TGT_GPR, 9'h000, 3'h0, 2);
        u_seq.group(1'h0, {4{32'h1234_5678}}, 3'h3);
        @(posedge clk_i);
        chk("previous result", pv, {4{32'h1234_5678}});
        u_seq.group(1'h1, {4{32'h0BAD_F00D}}, 3'h2);
        @(posedge clk_i);
        chk("previous result", pv, '0);
        rd(REG_SLOTS, 32'h0000_0005);
        u_seq.clause('{TWO_LINES, 1'h1, '{4'h9, 8'h10, 1'h0}, '{4'h5, 8'h20, 1'h1}});
        u_seq.set_loop(9'h008);
        u_seq.load({9'h007, 9'h1FF, 9'h005, 9'h002});
        op(KIND_SEL, 9'h005, 1'h1, IDX_Y, 2'h0, 7'h00, TGT_GPR, 9'h007, 3'h0, -1);
        chk("stall", stall_seen, 1'h1);
        op(KIND_CREG, 9'h00A, 1'h1, IDX_X, 2'h0, 7'h00, TGT_CREG, 9'h00C, 3'h0, 2);
        op(KIND_CREG, 9'h00A, 1'h1, IDX_Y, 2'h0, 7'h05, TGT_CREG, 9'h00F, 3'h0, 7);
        op(KIND_CREG, 9'h00A, 1'h1, IDX_W, 2'h0, 7'h64, TGT_CREG, 9'h011, 3'h0, 66);
        op(KIND_CREG, 9'h000, 1'h1, IDX_Z, 2'h0, 7'h00, TGT_CREG, 9'h000, 3'h2, 2);
        op(KIND_SEL, 9'h08A, 1'h1, IDX_X, 2'h0, 7'h00, TGT_KC0, 9'h000, 3'h2, 2);
        op(KIND_SEL, 9'h08A, 1'h1, IDX_LOOP, 2'h0, 7'h00, TGT_KC0, 9'h012, 3'h0, 2);
        chk("alternate", res_o.alt, 1'h1);
        chk("buffer line", {res_o.buf_id, res_o.line}, 12'h911);
        op(KIND_SEL, 9'h0A2, 1'h0, IDX_LOOP, 2'h0, 7'h00, TGT_KC1, 9'h002, 3'h0, 2);
        chk("buffer line", {res_o.buf_id, res_o.line}, 12'h528);
        op(KIND_PV, 9'h000, 1'h0, IDX_LOOP, 2'h0, 7'h00, TGT_PV, 9'h000, 3'h0, 2);
        wb(REG_STATUS, 1'h0, 32'h0000_0000, 4'hF);
        chk("index valid", q[0], 1'h1);
        u_seq.group(1'h0, {4{32'h1234_5678}}, 3'h1);
        u_seq.end_clause();
        @(posedge clk_i);
        chk("previous result", pv, '0);
        wb(REG_STATUS, 1'h0, 32'h0000_0000, 4'hF);
        chk("index valid", q[0], 1'h0);
        report_and_stop();
    end
endmodule : alu_operand_address_resolver_tb_top
